// ==== core/oplk_bit_timer.sv ====
`timescale 1ns/10ps
module oplk_bit_timer
   import oplk_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   input  wire logic         line_in,
   output logic              fall,
   output logic              bit_val,
   output logic              bit_ok,
   output logic [W-1:0]      high_cyc,
   output logic [W-1:0]      low_cyc
);
   logic         line_r;
   logic [W-1:0] hi_r;
   logic [W-1:0] lo_r;
   logic         seen_rise_r;

   assign fall = line_r & ~line_in;
   assign high_cyc = hi_r;
   assign low_cyc = lo_r;

   // count each phase between falling edges on the fast clock, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_r      <= 1'b1;
         hi_r        <= '0;
         lo_r        <= '0;
         seen_rise_r <= 1'b0;
      end else if (ce) begin
         line_r <= line_in;
         if (fall) begin
            hi_r        <= '0;
            lo_r        <= W'(1);
            seen_rise_r <= 1'b0;
         end else if (line_in) begin
            seen_rise_r <= 1'b1;
            if (hi_r != '1) hi_r <= hi_r + W'(1);
         end else if (!seen_rise_r && lo_r != '1) begin
            lo_r <= lo_r + W'(1);
         end
      end
   end

   // ratio test with no rate setting, so any rate decodes whose high phase stays below EOS_CYC
   always_comb begin
      bit_val = hi_r >= (lo_r << 1);
      bit_ok  = bit_val || (lo_r >= (hi_r << 1));
   end
endmodule

// ==== core/oplk_device.sv ====
`timescale 1ns/10ps
module oplk_device
   import oplk_pkg::*;
#(
   parameter logic [7:0] OWN_ADDR     = OWN_ADDR_DEFAULT,
   parameter int         ACK_CYC      = ACK_WIDTH_CYC,
   parameter int         SHUTDOWN_LIM = SHUTDOWN_CYC
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       ce,
   oplk_if.dev             lnk,
   output logic [4:0]      level_r,
   output logic            frame_ok,
   output logic            shutdown
);
   // gray order idle, bits, wait, ack: each step along the path flips one bit
   typedef enum logic [2:0] {
      OPLK_D_IDLE  = 3'b000,
      OPLK_D_BITS  = 3'b001,
      OPLK_D_WAIT  = 3'b011,
      OPLK_D_ACK   = 3'b010
   } oplk_dstate_t;

   oplk_dstate_t state_r;
   logic         fall;
   logic         bit_val;
   logic         bit_ok;
   logic [CNT_W-1:0] high_cyc;
   logic [CNT_W-1:0] low_cyc;
   logic [3:0]   nbits_r;
   logic [15:0]  shift_r;
   logic         bad_r;
   logic [CNT_W-1:0] tmr_r;
   logic [CNT_W-1:0] low_run_r;
   logic         pending_r;
   logic         eos;
   logic         ack_ok;
   logic         byte_end;   // fall closing the eighth bit of the address byte
   logic         frame_end;  // fall closing the sixteenth bit
   logic         valid_end;  // last cycle of the validity delay
   logic         load_ok;    // clean frame for this device with zero subaddress

   // phase timer measures high and low time between falling edges
   oplk_bit_timer #(.W(CNT_W)) u_timer (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .line_in  (lnk.line),
      .fall     (fall),
      .bit_val  (bit_val),
      .bit_ok   (bit_ok),
      .high_cyc (high_cyc),
      .low_cyc  (low_cyc)
   );

   // line idle high too long inside a byte: the partial frame is dropped
   assign eos = lnk.line && (high_cyc >= CNT_W'(EOS_CYC));
   assign ack_ok = shift_r[FLAG_BIT] && (shift_r[15:8] == OWN_ADDR) && !bad_r;

   // the fall into the end-of-stream low closes the address byte, and the fall
   // that starts the validity hold closes the data byte; a high end would leave
   // the last bit of a byte with no closing edge to measure against
   assign byte_end  = (state_r == OPLK_D_BITS) && fall && (nbits_r == 4'h7);
   assign frame_end = (state_r == OPLK_D_BITS) && fall && (nbits_r == 4'hf);
   assign valid_end = (state_r == OPLK_D_WAIT) && (tmr_r == CNT_W'(VALID_CYC - 1));
   assign load_ok   = !bad_r && (shift_r[15:8] == OWN_ADDR) &&
                      !shift_r[SUB_HI_BIT] && !shift_r[SUB_LO_BIT];

   // long low counter shuts the link down and resets level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_run_r <= '0;
         shutdown  <= 1'b0;
      end else if (ce) begin
         if (lnk.line) begin
            low_run_r <= '0;
            shutdown  <= 1'b0;
         end else if (low_run_r > CNT_W'(SHUTDOWN_LIM)) begin
            shutdown <= 1'b1;
         end else begin
            low_run_r <= low_run_r + CNT_W'(1);
         end
      end
   end

   // frame sequencer: bits, then the validity delay, then the pulse if asked for
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= OPLK_D_IDLE;
      end else if (ce) begin
         if (shutdown) begin
            state_r <= OPLK_D_IDLE;
         end else begin
            case (state_r)
               OPLK_D_IDLE: begin
                  if (fall) state_r <= OPLK_D_BITS;
               end
               OPLK_D_BITS: begin
                  // back to idle between the bytes, or on a long high abort
                  if (frame_end) state_r <= OPLK_D_WAIT;
                  else if (byte_end || eos) state_r <= OPLK_D_IDLE;
               end
               OPLK_D_WAIT: begin
                  if (valid_end) state_r <= ack_ok ? OPLK_D_ACK : OPLK_D_IDLE;
               end
               OPLK_D_ACK: begin
                  if (tmr_r == CNT_W'(ACK_CYC - 1)) state_r <= OPLK_D_IDLE;
               end
               default: state_r <= OPLK_D_IDLE;
            endcase
         end
      end
   end

   // one timer serves the validity delay and the pulse width; it restarts on
   // each entry so a pulse never inherits time from the delay before it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_r <= '0;
      end else if (ce) begin
         if (frame_end || valid_end) begin
            tmr_r <= '0;
         end else if ((state_r == OPLK_D_WAIT) || (state_r == OPLK_D_ACK)) begin
            tmr_r <= tmr_r + CNT_W'(1);
         end
      end
   end

   // bit collector; the pending flag keeps the address byte while the data
   // byte is on its way, so the first fall of that byte does not clear it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nbits_r   <= '0;
         shift_r   <= '0;
         bad_r     <= 1'b0;
         pending_r <= 1'b0;
      end else if (ce) begin
         if (shutdown) begin
            nbits_r   <= '0;
            bad_r     <= 1'b0;
            pending_r <= 1'b0;
         end else if (state_r == OPLK_D_IDLE) begin
            if (fall && !pending_r) begin
               nbits_r <= '0;
               bad_r   <= 1'b0;
            end
         end else if (state_r == OPLK_D_BITS) begin
            if (fall) begin
               // falling edge closes the previous bit, shift msb first
               shift_r <= {shift_r[14:0], bit_val};
               bad_r   <= bad_r | ~bit_ok;
               nbits_r <= nbits_r + 4'h1;
               if (byte_end) pending_r <= 1'b1;
            end else if (eos) begin
               nbits_r   <= '0;
               pending_r <= 1'b0;
            end
         end else begin
            pending_r <= 1'b0;
         end
      end
   end

   // level register loads only on a clean frame for this device and returns to
   // LEVEL_RESET on shutdown; the flag decides the pulse alone, so a frame without it still loads
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_r  <= LEVEL_RESET;
         frame_ok <= 1'b0;
      end else if (ce) begin
         frame_ok <= 1'b0;
         if (shutdown) begin
            level_r <= LEVEL_RESET;
         end else if (valid_end && load_ok) begin
            level_r  <= shift_r[4:0];
            frame_ok <= 1'b1;
         end
      end
   end

   // open drain: only ever pull low
   assign lnk.dev_drive_low = 1'b1;
   assign lnk.dev_oe = (state_r == OPLK_D_ACK);
endmodule

// ==== core/oplk_host.sv ====
`timescale 1ns/10ps
module oplk_host
   import oplk_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   oplk_if.host             lnk,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   typedef enum logic [2:0] {
      OPLK_H_IDLE  = 3'b000,
      OPLK_H_START = 3'b001,
      OPLK_H_LOW   = 3'b011,
      OPLK_H_HIGH  = 3'b010,
      OPLK_H_EOS   = 3'b110,
      OPLK_H_VAL   = 3'b111,
      OPLK_H_ACK   = 3'b101
   } oplk_hstate_t;

   oplk_hstate_t state_r;
   logic [15:0]  frame_r;
   logic [15:0]  bittime_r;
   logic [4:0]   idx_r;
   logic [15:0]  tmr_r;
   logic         acked_r;
   logic         done_r;
   logic         wr_pend_r;
   logic [7:0]   addr_r;
   logic         cur_bit;
   logic [15:0]  long_t;
   logic [15:0]  short_t;
   logic         go;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cur_bit = frame_r[4'(4'hf - idx_r[3:0])];
   // a bit is a third short, two thirds long; the short side is rounded down
   // so the long phase still holds twice the short one once each gains a cycle
   assign short_t = (bittime_r - 16'd2) / 16'd3;
   assign long_t = bittime_r - short_t;
   assign go = wr_pend_r && addr_r == REG_CMD && hwdata[CMD_GO_BIT] && state_r == OPLK_H_IDLE;

   // ahb-lite write capture, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r    <= '0;
         bittime_r <= BITTIME_RESET;
      end else if (ce) begin
         if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            addr_r    <= haddr[7:0];
         end
         if (wr_pend_r && addr_r == REG_BITTIME) bittime_r <= hwdata[15:0];
      end
   end

   // read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= '0;
      else if (ce && hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            REG_CMD:     hrdata <= {16'h0, frame_r};
            REG_STATUS:  hrdata <= {29'h0, acked_r, done_r, state_r != OPLK_H_IDLE};
            REG_BITTIME: hrdata <= {16'h0, bittime_r};
            default:     hrdata <= '0;
         endcase
      end
   end

   // link sequencer, open drain driver
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= OPLK_H_IDLE;
         frame_r <= '0;
         idx_r   <= '0;
         tmr_r   <= '0;
         acked_r <= 1'b0;
         done_r  <= 1'b0;
      end else if (ce) begin
         tmr_r <= tmr_r + 16'h1;
         case (state_r)
            OPLK_H_IDLE: begin
               if (go) begin
                  frame_r <= hwdata[15:0];
                  done_r  <= 1'b0;
                  acked_r <= 1'b0;
                  idx_r   <= '0;
                  tmr_r   <= '0;
                  state_r <= OPLK_H_START;
               end
            end
            OPLK_H_START: if (tmr_r >= 16'(START_CYC)) begin
               state_r <= OPLK_H_LOW;
               tmr_r   <= '0;
            end
            OPLK_H_LOW: if (tmr_r >= (cur_bit ? short_t : long_t)) begin
               state_r <= OPLK_H_HIGH;
               tmr_r   <= '0;
            end
            OPLK_H_HIGH: if (tmr_r >= (cur_bit ? long_t : short_t)) begin
               tmr_r <= '0;
               idx_r <= idx_r + 5'h1;
               if (idx_r == 5'd15) state_r <= OPLK_H_VAL; // last fall, hold low
               else if (idx_r == 5'd7) state_r <= OPLK_H_EOS;
               else state_r <= OPLK_H_LOW;
            end
            // low end-of-stream closes the address byte, then a fresh start high
            OPLK_H_EOS: if (tmr_r >= 16'(EOS_CYC + START_CYC)) begin
               state_r <= OPLK_H_LOW;
               tmr_r   <= '0;
            end
            OPLK_H_VAL: if (tmr_r >= 16'(VALID_CYC + 2)) begin
               state_r <= OPLK_H_ACK;
               tmr_r   <= '0;
            end
            OPLK_H_ACK: begin
               // sample after release; wait out any pulse before idling
               if (tmr_r == 16'd4) acked_r <= ~lnk.line;
               if (tmr_r > 16'd4 && lnk.line && tmr_r >= 16'(EOS_CYC)) begin
                  state_r <= OPLK_H_IDLE;
                  done_r  <= 1'b1;
               end
            end
            default: state_r <= OPLK_H_IDLE;
         endcase
      end
   end

   // host only ever pulls low; pullup returns the line high, and an open drain
   // stage needs no series resistor against an acknowledge
   assign lnk.host_drive_low = 1'b1;
   assign lnk.host_oe = state_r == OPLK_H_LOW || state_r == OPLK_H_VAL ||
                        (state_r == OPLK_H_EOS && tmr_r < 16'(EOS_CYC));
endmodule

// ==== core/oplk_if.sv ====
`timescale 1ns/10ps
interface oplk_if;
   logic host_drive_low;
   logic host_oe;
   logic dev_drive_low;
   logic dev_oe;
   logic line;
   // open drain wire with pullup on the host side
   assign line = ~((host_oe & host_drive_low) | (dev_oe & dev_drive_low));
   modport dev  (input line, output dev_drive_low, output dev_oe);
   modport host (input line, output host_drive_low, output host_oe);
endinterface

// ==== core/oplk_pkg.sv ====
package oplk_pkg;
   localparam int          CLK_MHZ          = 250;
   localparam int          START_NS         = 2000;
   localparam int          EOS_NS           = 2000;
   localparam int          ACK_WIDTH_US     = 512;
   localparam int          VALID_NS         = 2000;
   localparam int          SHUTDOWN_US      = 2500;
   localparam int          START_CYC        = (START_NS * CLK_MHZ + 999) / 1000;
   localparam int          EOS_CYC          = (EOS_NS * CLK_MHZ + 999) / 1000;
   localparam int          VALID_CYC        = (VALID_NS * CLK_MHZ + 999) / 1000;
   localparam int          ACK_WIDTH_CYC    = ACK_WIDTH_US * CLK_MHZ;
   localparam int          SHUTDOWN_CYC     = SHUTDOWN_US * CLK_MHZ;
   localparam logic [7:0]  OWN_ADDR_DEFAULT = 8'h5a; // arbitrary value
   localparam logic [4:0]  LEVEL_RESET      = 5'h1f;
   localparam int          FLAG_BIT         = 7;
   localparam int          SUB_HI_BIT       = 6;
   localparam int          SUB_LO_BIT       = 5;
   localparam int          CNT_W            = 20;
   // host register map over ahb-lite
   localparam logic [7:0]  REG_CMD          = 8'h00;
   localparam logic [7:0]  REG_STATUS       = 8'h04;
   localparam logic [7:0]  REG_BITTIME      = 8'h08;
   localparam int          CMD_GO_BIT       = 16;
   localparam logic [15:0] BITTIME_RESET    = 16'h00c8;
endpackage

// ==== dv/one_pin_level_program_link_tb.sv ====
`timescale 1ns/10ps
module one_pin_level_program_link_tb;
   import oplk_pkg::*;
   localparam int ACK_T  = 200;
   localparam int SHUT_T = 2000;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        ce = 1'b1;
   logic        hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rng, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  level_r, exp_lvl;
   logic        frame_ok, shutdown, got_ok;
   int          n_mismatch, samples_checked, cyc;

   assign hready = hreadyout;
   oplk_if lnk_if();
   oplk_device #(.ACK_CYC(ACK_T), .SHUTDOWN_LIM(SHUT_T)) oplk_device_inst (.hclk(hclk),
      .hresetn(hresetn), .ce(ce), .lnk(lnk_if.dev), .level_r(level_r), .frame_ok(frame_ok),
      .shutdown(shutdown));
   oplk_host oplk_host_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .lnk(lnk_if.host),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   oplk_monitor #(.ACK_CYC(ACK_T), .SHUTDOWN_LIM(SHUT_T)) oplk_monitor_inst (.hclk(hclk),
      .hresetn(hresetn), .host_drive_low(lnk_if.host_drive_low), .host_oe(lnk_if.host_oe),
      .dev_drive_low(lnk_if.dev_drive_low), .dev_oe(lnk_if.dev_oe), .line(lnk_if.line),
      .level_r(level_r), .frame_ok(frame_ok), .shutdown(shutdown));

   always #2 hclk = ~hclk;

   // latch the one-cycle load pulse so the frame task sees it later
   always @(posedge hclk) if (frame_ok === 1'b1) got_ok <= 1'b1;

   // a hung handshake ends the run with a mismatch
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         stop_test();
      end
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   // one single-word transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   // send one frame, wait for the host to finish, then judge load and ack
   task automatic frame(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] st;
      logic        ld;
      int          i;
      ld = (a == OWN_ADDR_DEFAULT) && (d[SUB_HI_BIT:SUB_LO_BIT] == 2'b00);
      got_ok <= 1'b0;
      ahb(1'b1, {24'h0, REG_CMD}, {15'h0, 1'b1, a, d}, st);
      i = 0;
      st = 32'h1;
      while ((st[0] !== 1'b0 || st[1] !== 1'b1) && i < 20000) begin
         ahb(1'b0, {24'h0, REG_STATUS}, 32'h0, st);
         i++;
      end
      if (ld) exp_lvl = d[4:0];
      chk_word("level", {27'h0, exp_lvl}, {27'h0, level_r});
      chk_bit("loaded", ld, got_ok);
      chk_bit("acked", d[FLAG_BIT] && a == OWN_ADDR_DEFAULT, st[2]);
   endtask

   initial begin
      int w;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      got_ok = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      cyc = 0;
      rng = 32'd92848;
      exp_lvl = LEVEL_RESET;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_word("level reset", {27'h0, LEVEL_RESET}, {27'h0, level_r});
      ahb(1'b0, {24'h0, REG_BITTIME}, 32'h0, rd);
      chk_word("bittime reset", {16'h0, BITTIME_RESET}, rd);
      ahb(1'b1, 32'h10, xs(), rd);
      ahb(1'b0, 32'h10, 32'h0, rd);
      chk_word("unmapped", 32'h0, rd);
      chk_bit("hresp", 1'b0, hresp);
      frame(OWN_ADDR_DEFAULT, 8'h80);
      frame(OWN_ADDR_DEFAULT, 8'h15);
      // a slow zero bit holds the line low past the shutdown limit, then reset mid-frame
      ahb(1'b1, {24'h0, REG_BITTIME}, 32'h0000_1838, rd);
      ahb(1'b1, {24'h0, REG_CMD}, 32'h0001_0000, rd);
      w = 0;
      while (shutdown !== 1'b1 && w < 8000) begin
         @(posedge hclk);
         w++;
      end
      @(posedge hclk);
      exp_lvl = LEVEL_RESET;
      chk_bit("shutdown", 1'b1, shutdown);
      chk_word("level shutdown", {27'h0, exp_lvl}, {27'h0, level_r});
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_bit("shutdown reset", 1'b0, shutdown);
      chk_word("level rereset", {27'h0, LEVEL_RESET}, {27'h0, level_r});
      ahb(1'b0, {24'h0, REG_BITTIME}, 32'h0, rd);
      chk_word("bittime rereset", {16'h0, BITTIME_RESET}, rd);
      frame(OWN_ADDR_DEFAULT ^ 8'h01, 8'h9f);
      frame(OWN_ADDR_DEFAULT, 8'he3);
      frame(OWN_ADDR_DEFAULT ^ 8'h80, 8'h8a);
      // random bit period keeps the decode honest across rates
      ahb(1'b1, {24'h0, REG_BITTIME}, 32'd150 + (xs() % 32'd100), rd);
      for (int k = 0; k < 6; k++) begin
         rd = xs();
         frame(rd[0] ? OWN_ADDR_DEFAULT : rd[15:8], rd[23:16]);
      end
      stop_test();
   end
endmodule

// ==== dv/oplk_monitor.sv ====
`timescale 1ns/10ps
module oplk_monitor
   import oplk_pkg::*;
#(
   parameter int ACK_CYC      = ACK_WIDTH_CYC,
   parameter int SHUTDOWN_LIM = SHUTDOWN_CYC
) (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       host_drive_low,
   input wire logic       host_oe,
   input wire logic       dev_drive_low,
   input wire logic       dev_oe,
   input wire logic       line,
   input wire logic [4:0] level_r,
   input wire logic       frame_ok,
   input wire logic       shutdown
);
   logic [CNT_W-1:0] ack_cnt_r;
   logic [CNT_W-1:0] low_cnt_r;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // pulldown run length, cleared as soon as the device lets go
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ack_cnt_r <= '0;
      else ack_cnt_r <= dev_oe ? ack_cnt_r + 1'b1 : '0;
   end

   // low run length; saturates so a stuck line cannot wrap back to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) low_cnt_r <= '0;
      else low_cnt_r <= line ? '0 : (&low_cnt_r ? low_cnt_r : low_cnt_r + 1'b1);
   end

   chk_ack_bound: assert property (ack_cnt_r <= CNT_W'(ACK_CYC))
      else $error("ack pulse too long");
   chk_ack_width: assert property ($fell(dev_oe) |-> ack_cnt_r == CNT_W'(ACK_CYC))
      else $error("ack pulse width wrong");
   chk_ack_delay: assert property ($rose(dev_oe) |-> low_cnt_r >= CNT_W'(VALID_CYC - 2))
      else $error("ack pulldown came early");
   chk_ack_pulls_low: assert property (dev_oe |-> !line)
      else $error("ack not low on the line");
   chk_host_holds: assert property ($rose(dev_oe) |-> host_oe && host_drive_low)
      else $error("host let go before ack");
   chk_level_cause: assert property (disable iff (!hresetn || shutdown)
      $changed(level_r) |-> (frame_ok || $past(frame_ok)))
      else $error("level changed without a frame");
   chk_shutdown_entry: assert property (low_cnt_r >= CNT_W'(SHUTDOWN_LIM + 2) |-> shutdown)
      else $error("no shutdown on long low");
   chk_line_released: assert property (!(host_oe || (dev_oe && dev_drive_low)) |-> line)
      else $error("released line not high");
endmodule
